//--- rtl/rx_cfg_map.svh
// Register offsets, write masks, reset values and decode constants.
`ifndef RX_CFG_MAP_SVH
`define RX_CFG_MAP_SVH

`define ADDR_W          8
`define OFF_ENABLES     8'h21
`define OFF_TECH        8'h22
`define OFF_NOISE_A     8'h23
`define OFF_NOISE_B     8'h24
`define OFF_AMP_STAT    8'h30
`define OFF_NOISE_STAT  8'h31

`define ENABLES_MASK    32'h0007_FFFF
`define TECH_MASK       32'hFFFF_FFFF
`define NOISE_A_MASK    32'h0EFF_FFFF
`define NOISE_B_MASK    32'h00FF_FFFF

`define ENABLES_RST     32'h0000_0000
`define TECH_RST        32'h0000_0003
`define NOISE_A_RST     32'h0000_0000
`define NOISE_B_RST     32'h0000_0000

`define NOISE_GO_BIT    24
`define NOISE_ON_BIT    0

`define THR_1_000       4'h8
`define THR_0_875       4'h7
`define THR_0_750       4'h6
`define THR_0_500       4'h4
`define THR_1_125       4'h9
`define THR_1_250       4'hA
`define THR_1_500       4'hC

`define CHECK_LEN_BASE  5'h02

`endif

//--- rtl/rx_cfg_pkg.sv
// Types shared by the receiver configuration bank and its users.
package rx_cfg_pkg;

  typedef enum logic [2:0] {
    MODE_A106     = 3'h0,
    MODE_EPC      = 3'h1,
    MODE_VICINITY = 3'h2,
    MODE_B        = 3'h3,
    MODE_OTHER    = 3'h4
  } rx_mode_t;

  typedef struct packed {
    logic       silence;
    logic       collision;
    logic       false_start;
    logic       resync;
    logic       disturbance;
  } rx_events_t;

  typedef struct packed {
    logic [1:0] collision_upper_slope_sel;
    logic [1:0] collision_lower_slope_sel;
    logic [6:0] invalid_noise_threshold;
    logic       amplitude_readback_en;
    logic       amplitude_tracking_en;
    logic       disturbance_reset_en;
    logic       silence_reset_en;
    logic       collision_reset_en;
    logic       false_start_reset_en;
    logic       resync_reset_en;
    logic       watchdog_reset_en;
  } enables_cfg_t;

  typedef struct packed {
    logic [1:0] oscillator_reload_sel;
    logic [2:0] response_delay_reload_sel;
    logic       guard_window_threshold_sel;
    logic       dc_spare;
    logic [1:0] decimation_rate_sel;
    logic [2:0] start_frame_sample_count;
    logic [2:0] matched_filter_choice;
    logic [1:0] matched_filter_gain;
    logic [1:0] combiner_lower_weight;
    logic       averager_gain;
    logic [1:0] averager_choice;
    logic [1:0] sync_filter_input;
    logic [1:0] sync_filter_choice;
    logic [2:0] rx_timeout_reload_sel;
    logic       restart_spare;
    logic [1:0] initial_invalid_check_len;
  } tech_cfg_t;

  typedef struct packed {
    logic [2:0] combiner_scale;
    logic       noise_estimate_go;
    logic       noise_estimate_fast;
    logic       input_select;
    logic [5:0] noise_coarse_window;
    logic [5:0] noise_detail_window;
    logic [2:0] noise_peak_scale;
    logic [1:0] noise_peak_absolute_limit;
    logic [1:0] noise_peak_relative_limit;
    logic [1:0] noise_average_window;
    logic       noise_detector_on;
  } noise_cfg_a_t;

  typedef struct packed {
    logic       quadrature_noise_force_en;
    logic       inphase_noise_force_en;
    logic [1:0] update_condition;
    logic [9:0] quadrature_noise_forced_value;
    logic [9:0] inphase_noise_forced_value;
  } noise_cfg_b_t;

  typedef struct packed {
    logic [9:0] quadrature;
    logic [9:0] inphase;
  } noise_pair_t;

endpackage : rx_cfg_pkg

//--- rtl/rx_cfg_regs.sv
// Reader receive configuration bank with its reset, watchdog, noise logic.
`timescale 1ns/1ps
// Function
// - Lower slope code 0..3 gives collision threshold 1, 0.875, 0.75, 0.5.
// - Upper slope code 0..3 gives collision threshold 1, 1.125, 1.25, 1.5.
// - Seven-bit noise threshold decides when received data is invalid.
// - Readback enable set stores measured amplitude; clear leaves it alone.
// - Tracking bit keeps amplitude tracking across the whole frame.
// - Disturbance reset applies only in A106, EPC and vicinity modes.
// - Silence detection resets the receiver only when enabled.
// - Collision detection resets the receiver only when enabled.
// - Start-of-frame false alarm resets the receiver only when enabled.
// - Re-synchronisation resets the receiver only when enabled.
// - Watchdog expiry resets the receiver only when enabled.
// - Fields select oscillator and response-delay counter reloads.
// - Three-bit field selects the watchdog counter reload value.
// - Check length codes 0..3 give 2, 4, 8, 16 samples; reset 3.
// - Bit 26 picks guard window threshold; bits 24:23 decimation rate.
// - Three-bit field sets vicinity start-of-frame sample count.
// - Fields choose matched filters and matched-filter gain.
// - Fields set combiner weight, averager and sync filter options.
// - Noise detector runs only when on; writing go with the on bit set in the same write starts estimation.
// - Six-bit fields give coarse and detail noise window lengths.
// - Peak absolute, relative limits and peak scale drive detection.
// - Two-bit field selects noise averaging window length.
// - Force enables replace measured I or Q noise with firmware value.
`include "rx_cfg_map.svh"

module rx_cfg_regs
  import rx_cfg_pkg::*;
#(
  parameter int AMP_W     = 8,
  parameter int WDOG_W    = 24,
  parameter int WDOG_BASE = 256
) (
  input  wire logic                CLOCK,
  input  wire logic                SRST,
  input  wire logic [`ADDR_W-1:0]  ADDR,
  input  wire logic [31:0]         WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [31:0]         RDATA,
  input  wire logic                RX_ACTIVE,
  input  rx_mode_t                 RX_MODE,
  input  rx_events_t               RX_EVENTS,
  input  wire logic [6:0]          NOISE_LEVEL,
  input  wire logic                AMP_VALID,
  input  wire logic [AMP_W-1:0]    AMP_MEAS,
  input  noise_pair_t              MEAS_NOISE,
  output enables_cfg_t             ENABLES_CFG,
  output tech_cfg_t                TECH_CFG,
  output noise_cfg_a_t             NOISE_CFG_A,
  output noise_cfg_b_t             NOISE_CFG_B,
  output logic      [3:0]          COL_LOW_THR,
  output logic      [3:0]          COL_HIGH_THR,
  output logic      [4:0]          INVALID_CHECK_LEN,
  output logic                     DATA_INVALID,
  output logic                     RX_RESET,
  output logic                     WDOG_EXPIRED,
  output logic      [AMP_W-1:0]    AMP_STATUS,
  output logic                     NOISE_START,
  output noise_pair_t              NOISE_REPORT
);

  function automatic logic [3:0] lower_thr(input logic [1:0] code);
    case (code)
      2'h0:    lower_thr = `THR_1_000;
      2'h1:    lower_thr = `THR_0_875;
      2'h2:    lower_thr = `THR_0_750;
      default: lower_thr = `THR_0_500;
    endcase
  endfunction : lower_thr

  function automatic logic [3:0] upper_thr(input logic [1:0] code);
    case (code)
      2'h0:    upper_thr = `THR_1_000;
      2'h1:    upper_thr = `THR_1_125;
      2'h2:    upper_thr = `THR_1_250;
      default: upper_thr = `THR_1_500;
    endcase
  endfunction : upper_thr

  logic [31:0]       reg_enables;
  logic [31:0]       reg_tech;
  logic [31:0]       reg_noise_a;
  logic [31:0]       reg_noise_b;
  logic [WDOG_W-1:0] wdog_count;

  enables_cfg_t ena;
  tech_cfg_t    tech;
  noise_cfg_a_t na;
  noise_cfg_b_t nb;
  assign ena  = enables_cfg_t'(reg_enables[18:0]);
  assign tech = tech_cfg_t'(reg_tech);
  assign na   = noise_cfg_a_t'(reg_noise_a[27:0]);
  assign nb   = noise_cfg_b_t'(reg_noise_b[23:0]);

  // Address decode.
  wire wr_ena  = WR && (ADDR == `OFF_ENABLES);
  wire wr_tech = WR && (ADDR == `OFF_TECH);
  wire wr_na   = WR && (ADDR == `OFF_NOISE_A);
  wire wr_nb   = WR && (ADDR == `OFF_NOISE_B);

  logic [31:0] read_mux;
  assign read_mux =
    (ADDR == `OFF_ENABLES)    ? reg_enables :
    (ADDR == `OFF_TECH)       ? reg_tech :
    (ADDR == `OFF_NOISE_A)    ? reg_noise_a :
    (ADDR == `OFF_NOISE_B)    ? reg_noise_b :
    (ADDR == `OFF_AMP_STAT)   ? 32'(AMP_STATUS) :
    (ADDR == `OFF_NOISE_STAT) ? {12'h000, NOISE_REPORT} :
                                32'h0000_0000;

  // Go is a strobe: it is never stored, so it always reads back zero.
  wire next_noise_start = wr_na && WDATA[`NOISE_GO_BIT]
                          && WDATA[`NOISE_ON_BIT];

  // Disturbance handling exists only in the three OOK-style modes.
  wire dist_mode = (RX_MODE == MODE_A106) || (RX_MODE == MODE_EPC)
                   || (RX_MODE == MODE_VICINITY);

  logic [WDOG_W-1:0] wdog_reload;
  assign wdog_reload = WDOG_W'(WDOG_BASE) << tech.rx_timeout_reload_sel;
  wire wdog_hit = RX_ACTIVE && (wdog_count == WDOG_W'(1));

  wire next_rx_reset =
      (RX_EVENTS.disturbance && ena.disturbance_reset_en && dist_mode)
    || (RX_EVENTS.silence     && ena.silence_reset_en)
    || (RX_EVENTS.collision   && ena.collision_reset_en)
    || (RX_EVENTS.false_start && ena.false_start_reset_en)
    || (RX_EVENTS.resync      && ena.resync_reset_en)
    || (wdog_hit              && ena.watchdog_reset_en);

  wire next_data_invalid = NOISE_LEVEL > ena.invalid_noise_threshold;

  noise_pair_t next_report;
  assign next_report.inphase =
    nb.inphase_noise_force_en ? nb.inphase_noise_forced_value
    : na.noise_detector_on    ? MEAS_NOISE.inphase
    : NOISE_REPORT.inphase;
  assign next_report.quadrature =
    nb.quadrature_noise_force_en ? nb.quadrature_noise_forced_value
    : na.noise_detector_on       ? MEAS_NOISE.quadrature
    : NOISE_REPORT.quadrature;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      reg_enables <= `ENABLES_RST;
      reg_tech    <= `TECH_RST;
      reg_noise_a <= `NOISE_A_RST;
      reg_noise_b <= `NOISE_B_RST;
    end else begin
      if (wr_ena)  reg_enables <= WDATA & `ENABLES_MASK;
      if (wr_tech) reg_tech    <= WDATA & `TECH_MASK;
      if (wr_na)   reg_noise_a <= WDATA & `NOISE_A_MASK;
      if (wr_nb)   reg_noise_b <= WDATA & `NOISE_B_MASK;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= RD ? read_mux : 32'h0000_0000;
    end
  end

  // The counter reloads between frames, so every frame starts a full period.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wdog_count   <= WDOG_W'(WDOG_BASE);
      WDOG_EXPIRED <= 1'b0;
    end else begin
      WDOG_EXPIRED <= wdog_hit;
      if (!RX_ACTIVE || RX_RESET || wdog_hit) begin
        wdog_count <= wdog_reload;
      end else begin
        wdog_count <= wdog_count - WDOG_W'(1);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ENABLES_CFG       <= enables_cfg_t'(`ENABLES_RST);
      TECH_CFG          <= tech_cfg_t'(`TECH_RST);
      NOISE_CFG_A       <= noise_cfg_a_t'(`NOISE_A_RST);
      NOISE_CFG_B       <= noise_cfg_b_t'(`NOISE_B_RST);
      COL_LOW_THR       <= `THR_1_000;
      COL_HIGH_THR      <= `THR_1_000;
      INVALID_CHECK_LEN <= `CHECK_LEN_BASE;
      DATA_INVALID      <= 1'b0;
      RX_RESET          <= 1'b0;
      AMP_STATUS        <= '0;
      NOISE_START       <= 1'b0;
      NOISE_REPORT      <= '0;
    end else begin
      ENABLES_CFG       <= ena;
      TECH_CFG          <= tech;
      NOISE_CFG_A       <= na;
      NOISE_CFG_B       <= nb;
      COL_LOW_THR       <= lower_thr(ena.collision_lower_slope_sel);
      COL_HIGH_THR      <= upper_thr(ena.collision_upper_slope_sel);
      INVALID_CHECK_LEN <= `CHECK_LEN_BASE
                           << tech.initial_invalid_check_len;
      DATA_INVALID      <= next_data_invalid;
      RX_RESET          <= next_rx_reset;
      if (AMP_VALID && ena.amplitude_readback_en) begin
        AMP_STATUS <= AMP_MEAS;
      end
      NOISE_START       <= next_noise_start;
      NOISE_REPORT      <= next_report;
    end
  end

  // Checks.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  property p_low_slope;
    wr_ena ##1 !wr_ena |=> COL_LOW_THR == lower_thr($past(WDATA[16:15], 2));
  endproperty
  a_low_slope: assert property (p_low_slope)
    else $error("lower collision threshold does not match its code");

  property p_high_slope;
    wr_ena && WDATA[18:17] == 2'h3 ##1 !wr_ena |=> COL_HIGH_THR == `THR_1_500;
  endproperty
  a_high_slope: assert property (p_high_slope)
    else $error("upper collision threshold is not 1.5 for code 3");

  property p_invalid;
    NOISE_LEVEL > ena.invalid_noise_threshold |=> DATA_INVALID;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("noise above threshold did not mark data invalid");

  property p_amp_hold;
    !ena.amplitude_readback_en |=> $stable(AMP_STATUS);
  endproperty
  a_amp_hold: assert property (p_amp_hold)
    else $error("amplitude status changed while readback disabled");

  property p_amp_load;
    AMP_VALID && ena.amplitude_readback_en |=> AMP_STATUS == $past(AMP_MEAS);
  endproperty
  a_amp_load: assert property (p_amp_load)
    else $error("measured amplitude not stored");

  property p_silence;
    RX_EVENTS.silence && ena.silence_reset_en |=> RX_RESET;
  endproperty
  a_silence: assert property (p_silence)
    else $error("enabled silence did not reset the receiver");

  property p_dist_mode;
    !RX_EVENTS.silence && !RX_EVENTS.collision && !RX_EVENTS.false_start
    && !RX_EVENTS.resync && !wdog_hit && RX_MODE == MODE_B |=> !RX_RESET;
  endproperty
  a_dist_mode: assert property (p_dist_mode)
    else $error("receiver reset in a mode without disturbance handling");

  property p_check_len;
    wr_tech ##1 !wr_tech |=> INVALID_CHECK_LEN == (`CHECK_LEN_BASE
                          << $past(WDATA[1:0], 2));
  endproperty
  a_check_len: assert property (p_check_len)
    else $error("invalid check length does not match its code");

  property p_start;
    wr_na |=> NOISE_START == $past(WDATA[24] && WDATA[0]);
  endproperty
  a_start: assert property (p_start)
    else $error("noise start pulse wrong");

  property p_force;
    nb.inphase_noise_force_en |=>
      NOISE_REPORT.inphase == $past(nb.inphase_noise_forced_value);
  endproperty
  a_force: assert property (p_force)
    else $error("forced inphase noise value not reported");

  property p_reserved;
    RD && ADDR == `OFF_NOISE_A |=> RDATA[31:28] == 4'h0 && !RDATA[24];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved noise bits read nonzero");

  property p_collision;
    RX_EVENTS.collision && ena.collision_reset_en |=> RX_RESET;
  endproperty
  a_collision: assert property (p_collision)
    else $error("enabled collision did not reset the receiver");

  property p_false_start;
    RX_EVENTS.false_start && ena.false_start_reset_en |=> RX_RESET;
  endproperty
  a_false_start: assert property (p_false_start)
    else $error("enabled false alarm did not reset the receiver");

  property p_resync;
    RX_EVENTS.resync && ena.resync_reset_en |=> RX_RESET;
  endproperty
  a_resync: assert property (p_resync)
    else $error("enabled resync did not reset the receiver");

  property p_wdog_reset;
    wdog_hit && ena.watchdog_reset_en |=> RX_RESET && WDOG_EXPIRED;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset)
    else $error("enabled watchdog expiry did not reset the receiver");

  property p_no_cause;
    RX_EVENTS == '0 && !wdog_hit |=> !RX_RESET;
  endproperty
  a_no_cause: assert property (p_no_cause)
    else $error("receiver reset without any cause");

  property p_dist_reset;
    RX_EVENTS.disturbance && ena.disturbance_reset_en
    && RX_MODE == MODE_EPC |=> RX_RESET;
  endproperty
  a_dist_reset: assert property (p_dist_reset)
    else $error("enabled disturbance did not reset the receiver");

  property p_wdog_reload;
    !RX_ACTIVE |=>
      wdog_count == (WDOG_W'(WDOG_BASE) << $past(tech.rx_timeout_reload_sel));
  endproperty
  a_wdog_reload: assert property (p_wdog_reload)
    else $error("watchdog reload value does not match its code");

  property p_track_copy;
    wr_ena ##1 !wr_ena |=>
      ENABLES_CFG.amplitude_tracking_en == $past(WDATA[6], 2);
  endproperty
  a_track_copy: assert property (p_track_copy)
    else $error("tracking enable not passed on");

  property p_reload_copy;
    wr_tech ##1 !wr_tech |=>
      TECH_CFG.oscillator_reload_sel == $past(WDATA[31:30], 2)
      && TECH_CFG.response_delay_reload_sel == $past(WDATA[29:27], 2);
  endproperty
  a_reload_copy: assert property (p_reload_copy)
    else $error("counter reload selections not passed on");

  property p_guard_copy;
    wr_tech ##1 !wr_tech |=>
      TECH_CFG.guard_window_threshold_sel == $past(WDATA[26], 2)
      && TECH_CFG.decimation_rate_sel == $past(WDATA[24:23], 2)
      && TECH_CFG.start_frame_sample_count == $past(WDATA[22:20], 2);
  endproperty
  a_guard_copy: assert property (p_guard_copy)
    else $error("guard, decimation or start frame field not passed on");

  property p_filter_copy;
    wr_tech ##1 !wr_tech |=>
      TECH_CFG.matched_filter_choice == $past(WDATA[19:17], 2)
      && TECH_CFG.matched_filter_gain == $past(WDATA[16:15], 2)
      && TECH_CFG.combiner_lower_weight == $past(WDATA[14:13], 2)
      && TECH_CFG.sync_filter_choice == $past(WDATA[7:6], 2);
  endproperty
  a_filter_copy: assert property (p_filter_copy)
    else $error("filter selection fields not passed on");

  property p_window_copy;
    wr_na ##1 !wr_na |=>
      NOISE_CFG_A.noise_coarse_window == $past(WDATA[21:16], 2)
      && NOISE_CFG_A.noise_detail_window == $past(WDATA[15:10], 2)
      && NOISE_CFG_A.noise_average_window == $past(WDATA[2:1], 2);
  endproperty
  a_window_copy: assert property (p_window_copy)
    else $error("noise window fields not passed on");

  property p_peak_copy;
    wr_na ##1 !wr_na |=>
      NOISE_CFG_A.noise_peak_absolute_limit == $past(WDATA[6:5], 2)
      && NOISE_CFG_A.noise_peak_relative_limit == $past(WDATA[4:3], 2)
      && NOISE_CFG_A.noise_peak_scale == $past(WDATA[9:7], 2);
  endproperty
  a_peak_copy: assert property (p_peak_copy)
    else $error("noise peak fields not passed on");

  property p_force_q;
    nb.quadrature_noise_force_en |=>
      NOISE_REPORT.quadrature == $past(nb.quadrature_noise_forced_value);
  endproperty
  a_force_q: assert property (p_force_q)
    else $error("forced quadrature noise value not reported");

  c_wdog_reset: cover property (wdog_hit && ena.watchdog_reset_en ##1 RX_RESET);
  c_noise_go:   cover property (NOISE_START);
  c_amp_load:   cover property (AMP_VALID && ena.amplitude_readback_en);
  c_force_q:    cover property (nb.quadrature_noise_force_en);

endmodule : rx_cfg_regs

//--- verif/reader_demod_noise_config_test.sv
// Self-checking bench for the receiver configuration register bank.
`timescale 1ns/1ps
`include "rx_cfg_map.svh"

module reader_demod_noise_config_test
  import rx_cfg_pkg::*;
;
  localparam logic [31:0] lo_thr [4] = '{32'h8, 32'h7, 32'h6, 32'h4};
  localparam logic [31:0] hi_thr [4] = '{32'h8, 32'h9, 32'hA, 32'hC};
  localparam logic [31:0] msk [4] = '{`ENABLES_MASK, `TECH_MASK,
                                      `NOISE_A_MASK, `NOISE_B_MASK};
  // Event bit order is disturbance, resync, false start, collision, silence.
  localparam int en_bit [5] = '{5, 1, 2, 3, 4};

  logic        clock       = 1'h0;
  logic        srst        = 1'h1;
  logic [7:0]  addr        = 8'h00;
  logic [31:0] wdata       = 32'h0;
  logic        wr          = 1'h0;
  logic        rd          = 1'h0;
  logic        rx_active   = 1'h0;
  logic        amp_valid   = 1'h0;
  rx_mode_t    rx_mode     = MODE_A106;
  rx_events_t  rx_events   = '0;
  logic [6:0]  noise_level = 7'h00;
  logic [7:0]  amp_meas    = 8'h00;
  noise_pair_t meas_noise  = '0;
  logic [31:0] rdata;
  logic [3:0]  col_low_thr;
  logic [3:0]  col_high_thr;
  logic [4:0]  check_len;
  logic        data_invalid;
  logic        rx_reset;
  logic        wdog_expired;
  logic        noise_start;
  enables_cfg_t en_cfg;
  tech_cfg_t   tech_cfg;
  noise_cfg_a_t na_cfg;
  noise_cfg_b_t nb_cfg;
  logic [7:0]  amp_status;
  noise_pair_t noise_report;
  logic [31:0] cfg_out [4];
  logic [31:0] e;
  logic        rd_seen     = 1'h0;
  logic [31:0] exp_q [$];
  logic [31:0] r;
  logic [31:0] v;
  int          n;
  int          fails       = 0;
  int          num_checks  = 0;

  always #4 clock = ~clock;

  assign cfg_out[0] = 32'(en_cfg);
  assign cfg_out[1] = 32'(tech_cfg);
  assign cfg_out[2] = 32'(na_cfg);
  assign cfg_out[3] = 32'(nb_cfg);

  rx_cfg_regs #(.WDOG_BASE(4)) i_rx_cfg_regs (
    .CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RX_ACTIVE(rx_active), .RX_MODE(rx_mode),
    .RX_EVENTS(rx_events), .NOISE_LEVEL(noise_level),
    .AMP_VALID(amp_valid), .AMP_MEAS(amp_meas), .MEAS_NOISE(meas_noise),
    .ENABLES_CFG(en_cfg), .TECH_CFG(tech_cfg), .NOISE_CFG_A(na_cfg),
    .NOISE_CFG_B(nb_cfg),
    .COL_LOW_THR(col_low_thr), .COL_HIGH_THR(col_high_thr),
    .INVALID_CHECK_LEN(check_len), .DATA_INVALID(data_invalid),
    .RX_RESET(rx_reset), .WDOG_EXPIRED(wdog_expired),
    .AMP_STATUS(amp_status), .NOISE_START(noise_start),
    .NOISE_REPORT(noise_report)
  );

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'h0;
  endtask : rd_reg

  task automatic fire(input logic [4:0] ev, input logic e);
    @(posedge clock);
    rx_events <= ev;
    @(posedge clock);
    rx_events <= '0;
    @(negedge clock);
    chk("receiver reset", 32'(rx_reset), 32'(e));
  endtask : fire

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // Read data stand only in the cycle after the strobe, so look mid-cycle.
  always @(posedge clock) rd_seen <= rd & ~srst;
  always @(negedge clock) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 32'h1, 32'h0);
      end else begin
        chk("read data", rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(96645));
    repeat (12) @(posedge clock);
    srst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'h21 + 8'(i), (i == 1) ? `TECH_RST : 32'h0);
    end
    rd_reg(8'h25, 32'h0);
    @(negedge clock);
    chk("reset check len", 32'(check_len), 32'h10);
    chk("reset low thr", 32'(col_low_thr), 32'h8);
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      v = $urandom();
      wr_reg(8'h21 + 8'(i), v);
      rd_reg(8'h21 + 8'(i), v & msk[i]);
      @(negedge clock);
      chk("config copy", cfg_out[i], v & msk[i]);
    end
    wr_reg(8'h25, 32'hFFFF_FFFF);
    rd_reg(8'h25, 32'h0);
    $display("test readback done");

    for (int c = 0; c < 4; c++) begin
      wr_reg(`OFF_ENABLES, {13'h0, c[1:0], c[1:0], 15'h0});
      wr_reg(`OFF_TECH, 32'(c));
      @(posedge clock);
      @(negedge clock);
      chk("low thr", 32'(col_low_thr), lo_thr[c]);
      chk("high thr", 32'(col_high_thr), hi_thr[c]);
      chk("check len", 32'(check_len), 32'h2 << c);
    end
    $display("test selections done");

    for (int k = 0; k < 5; k++) begin
      for (int on = 0; on < 2; on++) begin
        wr_reg(`OFF_ENABLES, 32'(on) << en_bit[k]);
        fire(5'h01 << k, on[0]);
      end
    end
    wr_reg(`OFF_ENABLES, 32'h20);
    // Only the first three reception modes honour the disturbance reset.
    for (int m = 0; m < 5; m++) begin
      @(posedge clock);
      rx_mode <= rx_mode_t'(m);
      fire(5'h01, m < 3);
    end
    $display("test reset causes done");

    wr_reg(`OFF_ENABLES, 32'h40 << 8);
    for (int d = 0; d < 2; d++) begin
      @(posedge clock);
      noise_level <= 7'h40 + 7'(d);
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk("data invalid", 32'(data_invalid), 32'(d));
    end
    $display("test invalid done");

    for (int on = 1; on >= 0; on--) begin
      wr_reg(`OFF_ENABLES, 32'h40 | (32'(on) << 7));
      v = $urandom();
      @(posedge clock);
      amp_meas <= v[7:0];
      amp_valid <= 1'h1;
      @(posedge clock);
      amp_valid <= 1'h0;
      if (on == 1) begin
        r = 32'(v[7:0]);
      end
      rd_reg(`OFF_AMP_STAT, r);
      chk("amp status", 32'(amp_status), r);
    end
    $display("test amplitude done");

    for (int b = 0; b < 2; b++) begin
      wr_reg(`OFF_NOISE_A, 32'h0100_0000 | 32'(b));
      @(negedge clock);
      chk("noise start", 32'(noise_start), 32'(b));
      @(negedge clock);
      chk("noise start end", 32'(noise_start), 32'h0);
    end
    r = $urandom();
    v = $urandom();
    @(posedge clock);
    meas_noise <= noise_pair_t'(r[19:0]);
    for (int f = 0; f < 4; f++) begin
      wr_reg(`OFF_NOISE_B, {8'h0, f[1:0], 2'h0, v[19:0]});
      repeat (2) @(posedge clock);
      e = {12'h0, f[1] ? v[19:10] : r[19:10], f[0] ? v[9:0] : r[9:0]};
      rd_reg(`OFF_NOISE_STAT, e);
      chk("noise report", 32'(noise_report), e);
    end
    // With the detector off and no force the last report must hold.
    wr_reg(`OFF_NOISE_A, 32'h0);
    wr_reg(`OFF_NOISE_B, 32'h0);
    @(posedge clock);
    meas_noise <= ~meas_noise;
    repeat (2) @(posedge clock);
    rd_reg(`OFF_NOISE_STAT, {12'h0, v[19:0]});
    $display("test noise done");

    wr_reg(`OFF_ENABLES, 32'h1);
    for (int s = 0; s < 2; s++) begin
      wr_reg(`OFF_TECH, 32'(s) << 3);
      repeat (2) @(posedge clock);
      rx_active <= 1'h1;
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (wdog_expired !== 1'h1 && n < 40);
      chk("wdog cycles", 32'(n), 32'((4 << s) + 1));
      chk("wdog reset", 32'(rx_reset), 32'h1);
      @(posedge clock);
      rx_active <= 1'h0;
    end
    $display("test watchdog done");

    @(posedge clock);
    srst <= 1'h1;
    @(posedge clock);
    srst <= 1'h0;
    rd_reg(`OFF_TECH, `TECH_RST);
    rd_reg(`OFF_ENABLES, 32'h0);
    repeat (2) @(posedge clock);
    $display("test second reset done");
    summarize();
  end
endmodule : reader_demod_noise_config_test
